// ### verilog/albx_pkg.sv
// Package: encodings, constants and carriers for the align/logic/branch unit
package albx_pkg;
   // ------------------------------------------------------------
   // Opcode encodings
   // ------------------------------------------------------------
   localparam logic [5:0] OP_SPECIAL = 6'h00;
   localparam logic [5:0] OP_REG_IMM_CLASS = 6'h01;
   localparam logic [5:0] OP_BRANCH_IF_EQUAL = 6'h04;
   localparam logic [5:0] OP_BITWISE_AND_IMM = 6'h0C;
   localparam logic [5:0] OP_COP1 = 6'h11;
   localparam logic [5:0] OP_COP1X = 6'h13;
   localparam logic [5:0] FN_AND = 6'h24;
   localparam logic [5:0] FN_PAIR_FUNNEL_ALIGN = 6'h1E;
   localparam logic [4:0] RT_BRANCH_NONNEG_CALL = 5'h11;
   localparam logic [4:0] COP1_BRANCH_CLASS = 5'h08;
   localparam logic [4:0] LINK_REG = 5'h1F;
   localparam logic [4:0] ZERO_REG = 5'h00;
   // ------------------------------------------------------------
   // Constants
   // ------------------------------------------------------------
   localparam logic [63:0] PC_STEP = 64'h0000_0000_0000_0004;
   localparam logic [63:0] LINK_STEP = 64'h0000_0000_0000_0008;
   localparam logic [2:0] ALIGN_ZERO = 3'h0;
   localparam logic [2:0] ALIGN_HALF = 3'h4;
   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [31:0] word;
      logic [63:0] pc;
   } albx_instr_type;
   typedef struct packed {
      logic valid;
      logic [4:0] index;
      logic [63:0] data;
   } albx_write_type;
   typedef struct packed {
      logic valid;
      logic [63:0] target;
   } albx_redirect_type;
   typedef struct packed {
      logic cop_unusable;
      logic reserved_instr;
      logic fp_unimplemented;
   } albx_except_type;
endpackage : albx_pkg

// ### verilog/albx_funnel.sv
// Paired-single byte funnel shifter
`timescale 1ns/1ns
module albx_funnel (
   // Operands
   input wire logic [63:0] src_a,
   input wire logic [63:0] src_b,
   input wire logic [2:0] byte_count,
   input wire logic big_endian,
   // Result
   output logic [63:0] result
);
   always_comb begin
      if (byte_count == albx_pkg::ALIGN_ZERO) begin
         result = src_a;
      end else if (byte_count == albx_pkg::ALIGN_HALF && big_endian) begin
         result = {src_a[31:0], src_b[63:32]};
      end else if (byte_count == albx_pkg::ALIGN_HALF) begin
         result = {src_b[31:0], src_a[63:32]};
      end else begin
         // Undefined counts: plain big-endian funnel, cheapest generalisation
         result = 64'({src_a, src_b} >> (7'd64 - {byte_count, 3'h0}));
      end
   end
endmodule : albx_funnel

// ### verilog/albx_unit.sv
// Decode and execute for align, AND, branch, call and FP-false branch
`timescale 1ns/1ns
module albx_unit #(
   parameter int NUM_CC = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Core state
   input wire logic big_endian,
   input wire logic cop1_usable,
   input wire logic paired_single_ok,
   input wire logic [NUM_CC-1:0] fp_condition_codes,
   // Instruction in
   input wire albx_pkg::albx_instr_type instr,
   // Register read ports
   output logic [4:0] gen_read_a_index,
   output logic [4:0] gen_read_b_index,
   input wire logic [63:0] gen_read_a_raw,
   input wire logic [63:0] gen_read_b_raw,
   output logic [4:0] float_read_a_index,
   output logic [4:0] float_read_b_index,
   input wire logic [63:0] float_read_a,
   input wire logic [63:0] float_read_b,
   // Results
   output albx_pkg::albx_write_type gen_write,
   output albx_pkg::albx_write_type float_write,
   output albx_pkg::albx_redirect_type redirect,
   output albx_pkg::albx_except_type except_out,
   output logic fp_ieee_exception
);
   if (NUM_CC < 1 || NUM_CC > 8) begin : g_num_cc_check
      $error("NUM_CC must be 1..8");
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ALBX_IDLE = 3'b001,
      ALBX_SLOT = 3'b010,
      ALBX_GO = 3'b100
   } albx_state_type;

   logic [5:0] opcode;
   logic [4:0] gen_source_a;
   logic [4:0] gen_source_b;
   logic [4:0] dest_field;
   logic [15:0] offset_field;
   logic [63:0] gen_a;
   logic [63:0] gen_b;
   logic [63:0] align_result;
   logic [2:0] fp_condition_select;
   logic is_and;
   logic is_and_imm;
   logic is_branch_if_equal;
   logic is_call;
   logic is_fp_false;
   logic is_align;
   logic fp_trap;
   logic [63:0] next_target;
   logic take;
   albx_state_type state;
   logic [63:0] pending_target;

   assign opcode = instr.word[31:26];
   assign gen_source_a = instr.word[25:21];
   assign gen_source_b = instr.word[20:16];
   assign dest_field = instr.word[15:11];
   assign offset_field = instr.word[15:0];
   assign fp_condition_select = instr.word[20:18];

   // Zero register forced to zero on read
   assign gen_a = (gen_source_a == albx_pkg::ZERO_REG) ? 64'h0 : gen_read_a_raw;
   assign gen_b = (gen_source_b == albx_pkg::ZERO_REG) ? 64'h0 : gen_read_b_raw;
   assign gen_read_a_index = gen_source_a;
   assign gen_read_b_index = gen_source_b;
   // Align layout: count reg [25:21], source b [20:16], source a [15:11], dest [10:6]
   assign float_read_a_index = instr.word[15:11];
   assign float_read_b_index = instr.word[20:16];

   assign is_and = instr.valid && opcode == albx_pkg::OP_SPECIAL
      && instr.word[5:0] == albx_pkg::FN_AND;
   assign is_and_imm = instr.valid && opcode == albx_pkg::OP_BITWISE_AND_IMM;
   // Only the r0,r0 form is handled here; it compares zero with zero
   assign is_branch_if_equal = instr.valid && opcode == albx_pkg::OP_BRANCH_IF_EQUAL
      && gen_source_a == albx_pkg::ZERO_REG && gen_source_b == albx_pkg::ZERO_REG;
   assign is_call = instr.valid && opcode == albx_pkg::OP_REG_IMM_CLASS
      && gen_source_a == albx_pkg::ZERO_REG && gen_source_b == albx_pkg::RT_BRANCH_NONNEG_CALL;
   // tf = 0, nd = 0 selects the plain false form
   assign is_fp_false = instr.valid && opcode == albx_pkg::OP_COP1
      && gen_source_a == albx_pkg::COP1_BRANCH_CLASS && instr.word[17:16] == 2'b00;
   assign is_align = instr.valid && opcode == albx_pkg::OP_COP1X
      && instr.word[5:0] == albx_pkg::FN_PAIR_FUNNEL_ALIGN;

   // Selector zero is also what the short form encodes
   assign take = is_branch_if_equal && (gen_a == gen_b) || is_call
      || is_fp_false && !fp_condition_codes[fp_condition_select];
   assign next_target = instr.pc + albx_pkg::PC_STEP
      + {{46{offset_field[15]}}, offset_field, 2'b00};
   assign fp_trap = (is_align || is_fp_false) && !cop1_usable;

   albx_funnel u_funnel (
      .src_a(float_read_a),
      .src_b(float_read_b),
      .byte_count(gen_a[2:0]),
      .big_endian(big_endian),
      .result(align_result)
   );

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gen_write <= '0;
      end else if (is_and && dest_field != albx_pkg::ZERO_REG) begin
         gen_write <= '{valid: 1'b1, index: dest_field, data: gen_a & gen_b};
      end else if (is_and_imm && gen_source_b != albx_pkg::ZERO_REG) begin
         gen_write <= '{valid: 1'b1, index: gen_source_b, data: gen_a & {48'h0, offset_field}};
      end else if (is_call) begin
         gen_write <= '{valid: 1'b1, index: albx_pkg::LINK_REG,
            data: instr.pc + albx_pkg::LINK_STEP};
      end else begin
         gen_write <= '0;
      end
   end

   // Whole 64-bit value in one cycle, never half written
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         float_write <= '0;
      end else if (is_align && !fp_trap && paired_single_ok) begin
         float_write <= '{valid: 1'b1, index: instr.word[10:6], data: align_result};
      end else begin
         float_write <= '0;
      end
   end

   // ------------------------------------------------------------
   // Exceptions
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         except_out <= '0;
      end else begin
         except_out.cop_unusable <= fp_trap;
         except_out.reserved_instr <= (is_align || is_fp_false) && cop1_usable
            && !paired_single_ok && is_align;
         except_out.fp_unimplemented <= 1'b0;
      end
   end
   // Align is a pure move; no IEEE flag ever comes from it
   assign fp_ieee_exception = 1'b0;

   // ------------------------------------------------------------
   // Delay-slot sequencing
   // ------------------------------------------------------------
   // Redirect waits for the slot instruction, so the slot is never squashed
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= ALBX_IDLE;
         pending_target <= 64'h0;
         redirect <= '0;
      end else begin
         redirect <= '0;
         case (state)
            ALBX_IDLE: begin
               if (take && !fp_trap) begin
                  pending_target <= next_target;
                  state <= ALBX_SLOT;
               end
            end
            ALBX_SLOT: begin
               if (instr.valid) begin
                  state <= ALBX_GO;
               end
            end
            ALBX_GO: begin
               redirect <= '{valid: 1'b1, target: pending_target};
               state <= ALBX_IDLE;
            end
            default: begin
               state <= ALBX_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_link_value: assert property (@(posedge clock) disable iff (sys_rst)
      is_call |=> gen_write.valid && gen_write.index == 5'h1F && gen_write.data == $past(instr.pc) + 64'h8)
      else $error("link value wrong");
   a_and_reg: assert property (@(posedge clock) disable iff (sys_rst)
      is_and && dest_field != 5'h0 |=> gen_write.data == ($past(gen_a) & $past(gen_b)))
      else $error("register and wrong");
   a_and_imm: assert property (@(posedge clock) disable iff (sys_rst)
      is_and_imm && gen_source_b != 5'h0 |=> gen_write.data[63:16] == 48'h0)
      else $error("immediate not zero extended");
   a_zero_write: assert property (@(posedge clock) disable iff (sys_rst)
      gen_write.valid |-> gen_write.index != 5'h0)
      else $error("write to zero register");
   a_align_copy: assert property (@(posedge clock) disable iff (sys_rst)
      is_align && cop1_usable && paired_single_ok && gen_a[2:0] == 3'h0
      |=> float_write.valid && float_write.data == $past(float_read_a))
      else $error("align zero not copy");
   a_align_big: assert property (@(posedge clock) disable iff (sys_rst)
      is_align && cop1_usable && paired_single_ok && gen_a[2:0] == 3'h4 && big_endian
      |=> float_write.data == {$past(float_read_a[31:0]), $past(float_read_b[63:32])})
      else $error("big endian align wrong");
   a_align_little: assert property (@(posedge clock) disable iff (sys_rst)
      is_align && cop1_usable && paired_single_ok && gen_a[2:0] == 3'h4 && !big_endian
      |=> float_write.data == {$past(float_read_b[31:0]), $past(float_read_a[63:32])})
      else $error("little endian align wrong");
   a_uncond_slot: assert property (@(posedge clock) disable iff (sys_rst)
      state == ALBX_IDLE && is_branch_if_equal ##1 instr.valid |=> ##1 redirect.valid)
      else $error("branch not taken after slot");
   a_fp_false: assert property (@(posedge clock) disable iff (sys_rst)
      state == ALBX_IDLE && is_fp_false && cop1_usable && fp_condition_codes[fp_condition_select]
      |=> state == ALBX_IDLE)
      else $error("fp false taken on true code");
   a_cop_trap: assert property (@(posedge clock) disable iff (sys_rst)
      (is_align || is_fp_false) && !cop1_usable |=> except_out.cop_unusable && !float_write.valid)
      else $error("coprocessor trap missing");
endmodule : albx_unit

// ### dv/albx_regfile_model.sv
// General and float register files that stand beside the unit
`timescale 1ns/1ns
module albx_regfile_model (
   // Clock
   input wire logic clock,
   // Read ports
   input wire logic [4:0] gen_read_a_index,
   input wire logic [4:0] gen_read_b_index,
   output logic [63:0] gen_read_a_raw,
   output logic [63:0] gen_read_b_raw,
   input wire logic [4:0] float_read_a_index,
   input wire logic [4:0] float_read_b_index,
   output logic [63:0] float_read_a,
   output logic [63:0] float_read_b,
   // Write ports
   input wire albx_pkg::albx_write_type gen_write,
   input wire albx_pkg::albx_write_type float_write
);
   logic [63:0] gregs [32];
   logic [63:0] fregs [32];
   // ------------------------------------------------------------
   // Reads
   // ------------------------------------------------------------
   // Raw entry zero may hold junk, so the unit has to mask it itself
   assign gen_read_a_raw = gregs[gen_read_a_index];
   assign gen_read_b_raw = gregs[gen_read_b_index];
   assign float_read_a = fregs[float_read_a_index];
   assign float_read_b = fregs[float_read_b_index];
   // ------------------------------------------------------------
   // Writes
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (gen_write.valid) gregs[gen_write.index] <= gen_write.data;
      if (float_write.valid) fregs[float_write.index] <= float_write.data;
   end
endmodule : albx_regfile_model

// ### dv/tb.sv
// Self-checking bench for the align, logic and branch unit
`timescale 1ns/1ns
module tb;
   logic clock, sys_rst, big_endian, cop1_usable, paired_single_ok;
   logic [7:0] fp_condition_codes;
   albx_pkg::albx_instr_type instr;
   albx_pkg::albx_write_type gen_write, float_write;
   albx_pkg::albx_redirect_type redirect;
   albx_pkg::albx_except_type except_out;
   logic fp_ieee_exception;
   logic [4:0] ga_i, gb_i, fa_i, fb_i;
   logic [63:0] ga_d, gb_d, fa_d, fb_d;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   localparam logic [63:0] VA = 64'hF0F0_1234_5678_9ABC;
   localparam logic [63:0] VB = 64'h7FF8_0001_FFFF_0000;
   localparam logic [31:0] SLOT = {albx_pkg::OP_SPECIAL, 5'h03, 5'h04, 5'h08, 5'h00, albx_pkg::FN_AND};
   albx_unit DUT (.clock(clock), .sys_rst(sys_rst), .big_endian(big_endian), .cop1_usable(cop1_usable),
      .paired_single_ok(paired_single_ok), .fp_condition_codes(fp_condition_codes), .instr(instr),
      .gen_read_a_index(ga_i), .gen_read_b_index(gb_i), .gen_read_a_raw(ga_d), .gen_read_b_raw(gb_d),
      .float_read_a_index(fa_i), .float_read_b_index(fb_i), .float_read_a(fa_d), .float_read_b(fb_d),
      .gen_write(gen_write), .float_write(float_write), .redirect(redirect), .except_out(except_out),
      .fp_ieee_exception(fp_ieee_exception));
   albx_regfile_model model (.clock(clock), .gen_read_a_index(ga_i), .gen_read_b_index(gb_i),
      .gen_read_a_raw(ga_d), .gen_read_b_raw(gb_d), .float_read_a_index(fa_i), .float_read_b_index(fb_i),
      .float_read_a(fa_d), .float_read_b(fb_d), .gen_write(gen_write), .float_write(float_write));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         final_report;
      end
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk
   // Hold keeps valid up so back-to-back issues never assign twice in one step
   task automatic issue(input logic [31:0] w, input logic [63:0] p, input logic hold);
      instr <= '{1'b1, w, p};
      @(posedge clock);
      #1;
      if (!hold) instr.valid <= 1'b0;
   endtask : issue
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_and;
      model.gregs[0] = 64'hDEAD_0000_0000_0001;
      model.gregs[3] = VA;
      model.gregs[4] = VB;
      issue(SLOT, 64'h100, 1'b1);
      chk(gen_write === {1'b1, 5'h08, VA & VB}, "and reg");
      issue({albx_pkg::OP_SPECIAL, 5'h00, 5'h04, 5'h06, 5'h00, albx_pkg::FN_AND}, 64'h104, 1'b1);
      chk(gen_write === {1'b1, 5'h06, 64'h0}, "and zero reg");
      issue({albx_pkg::OP_BITWISE_AND_IMM, 10'h067, 16'h8F0F}, 64'h108, 1'b1);
      chk(gen_write === {1'b1, 5'h07, 48'h0, VA[15:0] & 16'h8F0F}, "and imm");
   endtask : t_and
   task automatic t_align;
      logic [63:0] e;
      model.fregs[1] = VA;
      model.fregs[2] = VB;
      for (int k = 0; k < 4; k++) begin
         model.gregs[9] = k[1] ? 64'h1234_0000_0000_000C : 64'h1234_0000_0000_0008;
         big_endian <= ~k[0];
         e = !k[1] ? VA : (!k[0] ? {VA[31:0], VB[63:32]} : {VB[31:0], VA[63:32]});
         issue({albx_pkg::OP_COP1X, 20'h48823, albx_pkg::FN_PAIR_FUNNEL_ALIGN}, 64'h200, 1'b1);
         chk(float_write === {1'b1, 5'h03, e} && except_out === '0, "align");
         chk(fp_ieee_exception === 1'b0, "align ieee");
      end
   endtask : t_align
   task automatic t_trap;
      cop1_usable <= 1'b0;
      issue({albx_pkg::OP_COP1X, 20'h4A0C3, albx_pkg::FN_PAIR_FUNNEL_ALIGN}, 64'h300, 1'b1);
      chk(except_out.cop_unusable === 1'b1 && float_write.valid === 1'b0, "align unusable");
      issue({albx_pkg::OP_COP1, albx_pkg::COP1_BRANCH_CLASS, 5'h00, 16'h0004}, 64'h304, 1'b0);
      chk(except_out.cop_unusable === 1'b1, "fp branch unusable");
      cop1_usable <= 1'b1;
      paired_single_ok <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk(redirect.valid === 1'b0, "trapped branch redirect");
      issue({albx_pkg::OP_COP1X, 20'h4A0C3, albx_pkg::FN_PAIR_FUNNEL_ALIGN}, 64'h30C, 1'b1);
      chk(except_out.reserved_instr === 1'b1 && float_write.valid === 1'b0, "align reserved");
      paired_single_ok <= 1'b1;
   endtask : t_trap
   task automatic t_branch(input logic [31:0] w, input logic [63:0] p, input logic take, input logic link);
      logic [63:0] tgt;
      tgt = p + 64'h4 + {{46{w[15]}}, w[15:0], 2'b00};
      issue(w, p, 1'b1);
      chk(gen_write === (link ? {1'b1, 5'h1F, p + 64'h8} : 70'h0), "link");
      issue(SLOT, p + 64'h4, 1'b0);
      chk(gen_write.valid === 1'b1 && redirect.valid === 1'b0, "delay slot");
      @(posedge clock);
      #1;
      chk(redirect.valid === take && (!take || redirect.target === tgt), "redirect");
      @(posedge clock);
      #1;
   endtask : t_branch
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      big_endian = 1'b1;
      cop1_usable = 1'b1;
      paired_single_ok = 1'b1;
      fp_condition_codes = 8'h00;
      instr = '0;
      repeat (3) @(posedge clock);
      #1 sys_rst <= 1'b0;
      @(posedge clock);
      #1;
      chk(gen_write.valid === 1'b0 && redirect.valid === 1'b0 && except_out === '0, "reset outputs");
      t_and;
      t_align;
      t_trap;
      t_branch({albx_pkg::OP_BRANCH_IF_EQUAL, 10'h000, 16'hFFF0}, 64'h1000, 1'b1, 1'b0);
      t_branch({albx_pkg::OP_REG_IMM_CLASS, 5'h00, albx_pkg::RT_BRANCH_NONNEG_CALL, 16'h0010}, 64'h2000, 1'b1, 1'b1);
      for (int c = 0; c < 8; c++) begin
         for (int v = 0; v < 2; v++) begin
            fp_condition_codes <= v[0] ? ~(8'h01 << c) : (8'h01 << c);
            t_branch({albx_pkg::OP_COP1, albx_pkg::COP1_BRANCH_CLASS, c[2:0], 2'b00, 16'h0020}, 64'h3000, v[0], 1'b0);
         end
      end
      final_report;
   end
endmodule : tb
